// [logic/ire_pkg.sv]
// Package of constants and carrier types for the infrared pulse endec
package ire_pkg;
    // Baud ticks per bit slot
    localparam int unsigned IRE_SLOT_TICKS = 16;
    // Transmit zero pulse shape: low 7, high 3, low 6
    localparam logic [3:0] IRE_TX_PULSE_START = 4'h7;
    localparam logic [3:0] IRE_TX_PULSE_END = 4'hA;
    // Decoder counter landmarks
    localparam logic [3:0] IRE_RX_UPDATE_CNT = 4'h8;
    localparam logic [3:0] IRE_RX_WINDOW_OPEN_CNT = 4'hC;
    localparam logic [3:0] IRE_CNT_ZERO = 4'h0;
    localparam logic [3:0] IRE_CNT_LAST = 4'hF;
    // Divisor width and its reset value
    localparam int unsigned IRE_DIV_W = 16;
    localparam logic [15:0] IRE_DIV_RESET = 16'hFFFF;
    localparam logic [15:0] IRE_DIV_ONE = 16'h0001;

    // Decoder states
    typedef enum logic [1:0] {
        IRE_RX_IDLE,
        IRE_RX_FIRST,
        IRE_RX_WAIT,
        IRE_RX_OPEN
    } ire_rx_state_e;

    // Pin-side signals grouped together
    typedef struct packed {
        logic tx_pin;
        logic uart_rxd;
    } ire_pins_s;
endpackage : ire_pkg

// [logic/ire_baud_tick.sv]
// Baud tick generator: one pulse every divisor system clocks (16x bit rate)
`timescale 1ns/1ps
module ire_baud_tick
    import ire_pkg::*;
#(
    parameter int unsigned DIV_W = IRE_DIV_W
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [DIV_W-1:0] baud_divisor,
    output logic tick
);
    logic [DIV_W-1:0] cnt_r; // Counts system clocks within one tick period

    // Counter reloads after reaching divisor; divisor 0 is treated as 1
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_r <= DIV_W'(IRE_DIV_ONE);
            tick <= 1'b0;
        end
        else if (cnt_r >= baud_divisor)
        begin
            cnt_r <= DIV_W'(IRE_DIV_ONE);
            tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + DIV_W'(IRE_DIV_ONE);
            tick <= 1'b0;
        end
    end
endmodule : ire_baud_tick

// [logic/ire_endec.sv]
// Infrared pulse encoder and decoder between the UART and the IR transceiver
`timescale 1ns/1ps
module ire_endec
    import ire_pkg::*;
#(
    parameter int unsigned DIV_W = IRE_DIV_W
)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic infrared_enable,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic uart_txd,
    input wire logic ir_pulse_in,
    output logic ir_modulated_out,
    output logic uart_rxd,
    output logic baud_tick
);
    logic tick; // 16x bit-rate tick
    logic pin_meta_r; // First synchroniser stage
    logic pin_sync_r; // Second synchroniser stage
    logic pin_prev_r; // Previous synchronised level
    logic fall; // Falling edge on the IR receive stream
    logic [3:0] tx_cnt_r; // Position within transmit slot
    logic tx_bit_r; // Bit latched at slot start
    logic tx_busy_r; // Transmit slot in progress
    logic [3:0] rx_cnt_r; // Decoder local counter
    logic rx_bit_r; // Decoded bit awaiting update at count 8
    ire_rx_state_e rx_state_r; // Decoder state
    ire_pins_s pins_nxt; // Next values of pin-side outputs

    // Settings (enable, divisor) come straight from UART control inputs
    ire_baud_tick #(.DIV_W(DIV_W)) u_tick (
        .ref_clk(ref_clk),
        .reset(reset),
        .baud_divisor(baud_divisor),
        .tick(tick)
    );

    // Receive pin comes from outside; two flops before any use
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
            pin_prev_r <= 1'b1;
        end
        else
        begin
            pin_meta_r <= ir_pulse_in;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    // Transceiver pulses pull low on light; falling edge marks a pulse
    assign fall = pin_prev_r & ~pin_sync_r;

    // Encoder slot counter: a slot starts on a tick with no slot in progress or when
    // a previous slot ended; an idle high line simply yields slots of ones
    always_ff @(posedge ref_clk)
    begin
        if (reset || !infrared_enable)
        begin
            tx_cnt_r <= IRE_CNT_ZERO;
            tx_bit_r <= 1'b1;
            tx_busy_r <= 1'b0;
        end
        else if (tick)
        begin
            if (!tx_busy_r || tx_cnt_r == IRE_CNT_LAST)
            begin
                // Latch one UART bit per 16-tick slot
                tx_bit_r <= uart_txd;
                tx_cnt_r <= IRE_CNT_ZERO;
                tx_busy_r <= 1'b1;
            end
            else
            begin
                tx_cnt_r <= tx_cnt_r + 4'h1;
            end
        end
    end

    // Decoder state machine with local counter and sampling window
    always_ff @(posedge ref_clk)
    begin
        if (reset || !infrared_enable)
        begin
            rx_state_r <= IRE_RX_IDLE;
            rx_cnt_r <= IRE_CNT_ZERO;
            rx_bit_r <= 1'b1;
        end
        else if (tx_busy_r && !tx_bit_r)
        begin
            // Own light may echo back; ignore receive while sending zeros
            rx_state_r <= IRE_RX_IDLE;
            rx_cnt_r <= IRE_CNT_ZERO;
            rx_bit_r <= 1'b1;
        end
        else
        begin
            case (rx_state_r)
                IRE_RX_IDLE:
                begin
                    if (fall)
                    begin
                        // First edge from idle decodes as zero
                        rx_bit_r <= 1'b0;
                        rx_cnt_r <= IRE_CNT_ZERO;
                        rx_state_r <= IRE_RX_FIRST;
                    end
                end
                IRE_RX_FIRST, IRE_RX_WAIT:
                begin
                    // Edges before the window opens are ignored; the count keeps
                    // running so a stray edge cannot swallow a tick
                    if (tick)
                    begin
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r + 4'h1 == IRE_RX_UPDATE_CNT)
                        begin
                            // Decoded bit goes out now; wait for the window
                            rx_state_r <= IRE_RX_WAIT;
                        end
                        else if (rx_cnt_r + 4'h1 == IRE_RX_WINDOW_OPEN_CNT)
                        begin
                            rx_state_r <= IRE_RX_OPEN;
                        end
                    end
                end
                IRE_RX_OPEN:
                begin
                    if (fall)
                    begin
                        // Pulse inside window: zero, resynchronise counter
                        rx_bit_r <= 1'b0;
                        rx_cnt_r <= IRE_CNT_ZERO;
                        rx_state_r <= IRE_RX_FIRST;
                    end
                    else if (tick)
                    begin
                        rx_cnt_r <= rx_cnt_r + 4'h1;
                        if (rx_cnt_r + 4'h1 == IRE_RX_UPDATE_CNT)
                        begin
                            // Window closed empty: this bit is a one
                            rx_bit_r <= 1'b1;
                            rx_state_r <= IRE_RX_IDLE;
                        end
                    end
                end
                default:
                begin
                    rx_state_r <= IRE_RX_IDLE;
                end
            endcase
        end
    end

    // Next pin-side values; with infrared enabled the UART only sees the rebuilt level, so
    // counter resyncs never produce extra UART edges
    always_comb
    begin
        pins_nxt.tx_pin = 1'b0;
        pins_nxt.uart_rxd = uart_rxd;
        if (infrared_enable)
        begin
            // Zero slot: high only during ticks 7..9
            if (tx_busy_r && !tx_bit_r && tx_cnt_r >= IRE_TX_PULSE_START
                && tx_cnt_r < IRE_TX_PULSE_END)
            begin
                pins_nxt.tx_pin = 1'b1;
            end
            // Update UART input at count 8 or when the window closes empty
            if (rx_cnt_r == IRE_RX_UPDATE_CNT || rx_state_r == IRE_RX_IDLE)
            begin
                pins_nxt.uart_rxd = rx_bit_r;
            end
        end
        else
        begin
            // Bypass: raw UART line drives the pin, pin feeds UART
            pins_nxt.tx_pin = uart_txd;
            pins_nxt.uart_rxd = pin_sync_r;
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ir_modulated_out <= 1'b0;
            uart_rxd <= 1'b1;
            baud_tick <= 1'b0;
        end
        else
        begin
            ir_modulated_out <= pins_nxt.tx_pin;
            uart_rxd <= pins_nxt.uart_rxd;
            baud_tick <= tick;
        end
    end
endmodule : ire_endec

// [tb/ire_endec_props.sv]
// Port checker for the infrared pulse endec
`timescale 1ns/1ps
module ire_endec_props
    import ire_pkg::*;
#(parameter int unsigned DIV_W = IRE_DIV_W)
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic infrared_enable,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic uart_txd,
    input wire logic ir_pulse_in,
    input wire logic ir_modulated_out,
    input wire logic uart_rxd,
    input wire logic baud_tick
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    logic [6:0] tx_hi_r; // Cycles of idle transmit line
    logic [6:0] rx_hi_r; // Cycles of idle receive pin
    // Both counters saturate so a long idle never wraps under the limit
    always_ff @(posedge ref_clk)
        tx_hi_r <= (reset || !infrared_enable || !uart_txd) ? 7'h00 : tx_hi_r + 7'(~&tx_hi_r);
    always_ff @(posedge ref_clk)
        rx_hi_r <= (reset || !infrared_enable || !ir_pulse_in) ? 7'h00 : rx_hi_r + 7'(~&rx_hi_r);
    // Three ticks of two clocks high, then low
    sequence s_pulse_hi;
        ir_modulated_out [*6] ##1 !ir_modulated_out;
    endsequence
    a_reset_idle_out: assert property (disable iff (1'b0) reset |=>
        !ir_modulated_out && uart_rxd && !baud_tick) else $error("outputs not idle after reset");
    a_tick_period: assert property (baud_tick && baud_divisor == 16'h0002 |=>
        !baud_tick ##1 baud_tick) else $error("baud tick spacing wrong");
    a_zero_pulse_width: assert property ($rose(ir_modulated_out) && infrared_enable
        && baud_divisor == 16'h0002 |-> s_pulse_hi) else $error("pulse width wrong");
    a_one_stays_low: assert property (tx_hi_r > 7'h40 |-> !ir_modulated_out)
        else $error("pulse sent for a one");
    a_bypass_tx: assert property (!infrared_enable |=>
        ir_modulated_out == $past(uart_txd)) else $error("bypass transmit wrong");
    a_rx_idle_one: assert property (rx_hi_r > 7'h64 |-> uart_rxd)
        else $error("receive line low without pulses");
    a_rx_zero_hold: assert property ($fell(uart_rxd) && infrared_enable |->
        !uart_rxd [*8]) else $error("decoded zero too short");
    // At this divisor the pin was low 15 to 20 clocks before the rebuilt fall
    a_rx_edge_cause: assert property ($fell(uart_rxd) && infrared_enable
        && baud_divisor == 16'h0002 |-> !$past(ir_pulse_in, 18))
        else $error("receive fell without pin edge");
endmodule : ire_endec_props
bind ire_endec ire_endec_props #(.DIV_W(DIV_W)) i_props (.ref_clk(ref_clk), .reset(reset),
    .infrared_enable(infrared_enable), .baud_divisor(baud_divisor), .uart_txd(uart_txd),
    .ir_pulse_in(ir_pulse_in), .ir_modulated_out(ir_modulated_out), .uart_rxd(uart_rxd),
    .baud_tick(baud_tick));

// [tb/ire_xcvr_model.sv]
// Behavioural infrared transceiver: sends pulse frames, counts light pulses
`timescale 1ns/1ps
module ire_xcvr_model
(
    input wire logic ref_clk,
    input wire logic baud_tick,
    input wire logic led_in,
    input wire logic send,
    input wire logic [9:0] frame,
    output logic pin_out = 1'b1,
    output logic busy = 1'b0,
    output int pulse_cnt = 0
);
    logic led_q = 1'b0; // Last light level
    logic [9:0] sh_r; // Frame bits, first bit at the bottom
    logic [3:0] tk_r; // Tick within the slot
    logic [3:0] bit_r; // Slot within the frame
    // Light pulses are counted on their rising edge
    always @(posedge ref_clk)
    begin
        led_q <= led_in;
        pulse_cnt <= pulse_cnt + int'(led_in && !led_q);
    end
    // Idle pin rests high on its pull-up; a zero is low for ticks 7 to 9
    always @(posedge ref_clk)
    begin
        if (send && !busy)
        begin
            busy <= 1'b1;
            sh_r <= frame;
            tk_r <= 4'h0;
            bit_r <= 4'h0;
        end
        else if (busy && baud_tick)
        begin
            pin_out <= sh_r[0] || tk_r < 4'h7 || tk_r > 4'h9;
            tk_r <= tk_r + 4'h1;
            if (tk_r == 4'hF)
            begin
                sh_r <= sh_r >> 1;
                bit_r <= bit_r + 4'h1;
                busy <= (bit_r != 4'h9);
            end
        end
    end
endmodule : ire_xcvr_model

// [tb/infrared_pulse_endec_tb_top.sv]
// Testbench for the infrared pulse endec
`timescale 1ns/1ps
module infrared_pulse_endec_tb_top;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic infrared_enable = 1'b1; // Enabled before traffic
    logic [15:0] baud_divisor = 16'h0002; // Nonzero keeps ticks
    logic uart_txd = 1'b1;
    logic send = 1'b0;
    logic [9:0] frame = 10'h3FF;
    logic ir_pulse_in, ir_modulated_out, uart_rxd, baud_tick, busy;
    int pulse_cnt;
    int err_total = 0;
    int num_checks = 0;
    ire_endec i_dut (.ref_clk(ref_clk), .reset(reset), .infrared_enable(infrared_enable),
        .baud_divisor(baud_divisor), .uart_txd(uart_txd), .ir_pulse_in(ir_pulse_in),
        .ir_modulated_out(ir_modulated_out), .uart_rxd(uart_rxd), .baud_tick(baud_tick));
    ire_xcvr_model i_xcvr (.ref_clk(ref_clk), .baud_tick(baud_tick), .led_in(ir_modulated_out),
        .send(send), .frame(frame), .pin_out(ir_pulse_in), .busy(busy), .pulse_cnt(pulse_cnt));
    initial forever #50 ref_clk = ~ref_clk;
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_val
    // Bounded wait for n baud ticks; a stuck tick ends the run
    task automatic wait_ticks(input int n);
        for (int k = 0; n > 0; k++)
        begin
            @(posedge ref_clk);
            #1;
            n -= int'(baud_tick === 1'b1);
            if (k > 4000)
            begin
                err_total++;
                stop_test();
            end
        end
    endtask : wait_ticks
    // One frame out: data zeros at bits 1,3,4,6 plus start give five pulses
    task automatic tx_frame_test();
        logic [9:0] bits;
        int base;
        bits = {1'b1, 8'hA5, 1'b0};
        base = pulse_cnt;
        for (int i = 0; i < 10; i++)
        begin
            uart_txd = bits[i];
            wait_ticks(16);
        end
        wait_ticks(24);
        check_val(16'(pulse_cnt - base), 16'h0005);
    endtask : tx_frame_test
    // One frame in, sampled mid-bit on the rebuilt line
    task automatic rx_frame_test();
        logic [7:0] got;
        int k;
        frame = {1'b1, 8'h3C, 1'b0};
        send = 1'b1;
        @(posedge ref_clk);
        #1 send = 1'b0;
        for (k = 0; k < 2000 && uart_rxd !== 1'b0; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        check_val(16'(k < 2000), 16'h0001);
        // Half a slot takes us to the middle of the rebuilt start bit
        wait_ticks(8);
        for (int i = 0; i < 8; i++)
        begin
            wait_ticks(16);
            got[i] = uart_rxd;
        end
        check_val({8'h00, got}, 16'h003C);
        wait_ticks(40);
        check_val({15'h0000, uart_rxd}, 16'h0001);
    endtask : rx_frame_test
    // Disabled: raw lines pass through
    task automatic bypass_test();
        int k;
        infrared_enable = 1'b0;
        uart_txd = 1'b0;
        wait_ticks(2);
        check_val({15'h0000, ir_modulated_out}, 16'h0000);
        uart_txd = 1'b1;
        wait_ticks(2);
        check_val({14'h0000, ir_modulated_out, uart_rxd}, 16'h0003);
        // A start pulse on the pin must bring the UART line low within 200 clocks
        frame = 10'h3FE;
        send = 1'b1;
        @(posedge ref_clk);
        #1 send = 1'b0;
        for (k = 0; k < 200 && uart_rxd !== 1'b0; k++)
        begin
            @(posedge ref_clk);
            #1;
        end
        check_val(16'(k < 200), 16'h0001);
        wait_ticks(160);
        infrared_enable = 1'b1;
    endtask : bypass_test
    initial
    begin
        repeat (3) @(posedge ref_clk);
        #1 reset = 1'b0;
        check_val({14'h0000, uart_rxd, ir_modulated_out}, 16'h0002);
        tx_frame_test();
        wait_ticks(32);
        rx_frame_test();
        bypass_test();
        stop_test();
    end
endmodule : infrared_pulse_endec_tb_top
